/* File: shared/osc_pkg.sv */
// constants, types and register map of the clock source switch
// assumes a 50 MHz apb clock and a scaled internal oscillator model
package osc_pkg;

    // -----------------------------
    // register map
    // -----------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] TRIM_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;

    // ctrl field positions
    localparam int SRC_POS = 0;
    localparam int RNG_POS = 2;
    localparam int FRQ_POS = 4;
    localparam int REQ_POS = 6;
    localparam int ENG_POS = 7;
    localparam int OUT_POS = 8;
    localparam int KIS_POS = 9;

    // reset values
    localparam logic [7:0] TRIM_RST = 8'h80;
    localparam logic [1:0] FRQ_RST  = 2'h0;

    // source select codes
    localparam logic [1:0] SRC_INT = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_RC  = 2'h2;
    localparam logic [1:0] SRC_XTL = 2'h3;

    // internal oscillator half periods in pclk cycles (scaled model)
    localparam logic [11:0] HALF_4M0  = 12'h500;
    localparam logic [11:0] HALF_8M0  = 12'h280;
    localparam logic [11:0] HALF_12M8 = 12'h190;
    localparam int          TRIM_SHIFT = 9;   // one step ~0.2 %

    // edges of the new source seen before changeover
    localparam logic [1:0] EDGE_COUNT = 2'h2;

    typedef enum {S_INT, S_CHECK, S_GAP_IN, S_EXT, S_GAP_OUT} sw_state_t;

    typedef struct packed {
        logic       keep_stop;
        logic       out_en;
        logic       ext_req;
        logic [1:0] freq;
        logic [1:0] range;
        logic [1:0] src;
    } ctrl_t;

endpackage

/* File: core/clock_source_select_switch.sv */
// apb reachable clock source select and switch control
// assumes pins arrive unsynchronised and the siu shares pclk
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
module clock_source_select_switch
    import osc_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        stop_mode,
    input  wire logic        oscillator_run_enable,
    input  wire logic        clock_input_pin,
    input  wire logic        crystal_clock,
    input  wire logic        resistor_cap_clock,
    output logic             aux_pin_o,
    output logic             aux_pin_oe,
    output logic             aux_pin_free,
    output logic             clock_input_pin_free,
    output logic             crystal_amp_enable,
    output logic [1:0]       crystal_range_select,
    output logic             rc_osc_enable,
    output logic             internal_osc_clock,
    output logic             quad_rate_bus_clock,
    output logic             double_rate_bus_clock,
    output logic             external_clock_engaged
);

    // -----------------------------
    // pin synchronisers
    // -----------------------------
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;

    // two flops, then an edge history flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
        end else begin
            pin_s1_q <= {resistor_cap_clock, crystal_clock, clock_input_pin};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // -----------------------------
    // registers
    // -----------------------------
    ctrl_t      ctrl_q;
    logic [7:0] trim_q;
    sw_state_t  state_q;
    logic       eng_q;
    logic       int_run;

    logic wr_en;
    logic rd_en;
    logic hit;

    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~penable & ~pwrite;
    assign hit     = (paddr == CTRL_OFS) | (paddr == TRIM_OFS)
                   | (paddr == STAT_OFS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // control register; ext mode clears clock out enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q      <= '0;
            ctrl_q.freq <= FRQ_RST;
        end else if (wr_en && paddr == CTRL_OFS) begin
            ctrl_q.src       <= pwdata[SRC_POS +: 2];
            ctrl_q.range     <= pwdata[RNG_POS +: 2];
            ctrl_q.freq      <= pwdata[FRQ_POS +: 2];
            ctrl_q.ext_req   <= pwdata[REQ_POS];
            ctrl_q.keep_stop <= pwdata[KIS_POS];
            ctrl_q.out_en    <= pwdata[OUT_POS]
                              & (pwdata[SRC_POS +: 2] != SRC_EXT);
        end else if (ctrl_q.src == SRC_EXT) begin
            ctrl_q.out_en <= 1'b0;
        end
    end

    // trim keeps reset value until software writes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q <= TRIM_RST;
        end else if (wr_en && paddr == TRIM_OFS) begin
            trim_q <= pwdata[7:0];
        end
    end

    // read data is captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            case (paddr)
                CTRL_OFS: prdata <= {22'h0, ctrl_q.keep_stop, ctrl_q.out_en,
                                     eng_q, ctrl_q.ext_req, ctrl_q.freq,
                                     ctrl_q.range, ctrl_q.src};
                TRIM_OFS: prdata <= {24'h0, trim_q};
                STAT_OFS: prdata <= {29'h0, int_run, eng_q,
                                     (state_q == S_CHECK)};
                default:  prdata <= 32'h0000_0000;
            endcase
        end
    end

    // -----------------------------
    // internal oscillator model
    // -----------------------------
    logic        osc_allow;
    logic [11:0] half_base;
    logic [12:0] half_len;
    logic signed [21:0] trim_prod;
    logic [11:0] osc_cnt_q;
    logic        int_clk_q;

    // wait has no effect; stop halts unless kept running
    assign osc_allow = oscillator_run_enable | ctrl_q.keep_stop
                     | ~stop_mode;
    assign int_run   = osc_allow & ~eng_q;

    // nominal half period per frequency choice
    always_comb begin
        case (ctrl_q.freq)
            2'h1:    half_base = HALF_8M0;
            2'h2:    half_base = HALF_12M8;
            default: half_base = HALF_4M0;
        endcase
    end

    // signed trim, larger value gives longer period; product kept wide
    assign trim_prod = $signed({{14{~trim_q[7]}}, ~trim_q[7], trim_q[6:0]})
                     * $signed({10'h000, half_base});
    assign half_len  = 13'({1'b0, half_base} + 13'(trim_prod >>> TRIM_SHIFT));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_cnt_q <= 12'h000;
            int_clk_q <= 1'b0;
        end else if (!int_run) begin
            osc_cnt_q <= 12'h000;
        end else if ({1'b0, osc_cnt_q} + 13'h1 >= half_len) begin
            osc_cnt_q <= 12'h000;
            int_clk_q <= ~int_clk_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 12'h001;
        end
    end

    assign internal_osc_clock = int_clk_q;

    // -----------------------------
    // source switch state machine
    // -----------------------------
    logic       ext_lvl;
    logic       ext_rise;
    logic [1:0] edge_q;
    logic       back_req;

    // level of the chosen external source
    always_comb begin
        case (ctrl_q.src)
            SRC_EXT: ext_lvl = pin_s2_q[0];
            SRC_RC:  ext_lvl = pin_s2_q[2];
            SRC_XTL: ext_lvl = pin_s2_q[1];
            default: ext_lvl = 1'b0;
        endcase
    end

    assign ext_rise = ext_lvl & ~(ctrl_q.src == SRC_RC ? pin_s3_q[2]
                    : ctrl_q.src == SRC_XTL ? pin_s3_q[1] : pin_s3_q[0]);
    assign back_req = (ctrl_q.src == SRC_INT) & ~ctrl_q.ext_req;

    // request, two edges, gap cycle, engaged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= S_INT;
            edge_q  <= 2'h0;
            eng_q   <= 1'b0;
        end else begin
            case (state_q)
                S_INT: begin
                    edge_q <= 2'h0;
                    if (ctrl_q.ext_req && ctrl_q.src != SRC_INT) begin
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (!ctrl_q.ext_req || ctrl_q.src == SRC_INT) begin
                        state_q <= S_INT;
                    end else if (ext_rise) begin
                        edge_q <= edge_q + 2'h1;
                        if (edge_q + 2'h1 == EDGE_COUNT) begin
                            state_q <= S_GAP_IN;
                        end
                    end
                end
                S_GAP_IN: begin
                    eng_q   <= 1'b1;
                    state_q <= S_EXT;
                end
                S_EXT: begin
                    if (back_req) begin
                        state_q <= S_GAP_OUT;
                    end
                end
                S_GAP_OUT: begin
                    eng_q   <= 1'b0;
                    state_q <= S_INT;
                end
                default: state_q <= S_INT;
            endcase
        end
    end

    assign external_clock_engaged = eng_q;

    // -----------------------------
    // clock mux and dividers
    // -----------------------------
    logic quad_d;
    logic quad_q;
    logic dbl_q;

    // gap states hold the output so no runt pulse forms
    always_comb begin
        case (state_q)
            S_EXT:     quad_d = ext_lvl;
            S_GAP_IN:  quad_d = quad_q;
            S_GAP_OUT: quad_d = quad_q;
            default:   quad_d = int_clk_q;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_q <= 1'b0;
            dbl_q  <= 1'b0;
        end else begin
            quad_q <= quad_d;
            if (quad_d && !quad_q) begin
                dbl_q <= ~dbl_q;
            end
        end
    end

    assign quad_rate_bus_clock   = quad_q;
    assign double_rate_bus_clock = dbl_q;

    // -----------------------------
    // pin ownership
    // -----------------------------
    logic xtal_sel;
    logic drive_clk;

    assign xtal_sel  = (ctrl_q.src == SRC_XTL);
    assign drive_clk = ctrl_q.out_en & ((ctrl_q.src == SRC_INT)
                     | (ctrl_q.src == SRC_RC));

    // aux pin: amplifier output, clock out or free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_pin_o  <= 1'b0;
            aux_pin_oe <= 1'b0;
        end else begin
            aux_pin_oe <= xtal_sel | drive_clk;
            aux_pin_o  <= xtal_sel ? ~pin_s2_q[0] : quad_d;
        end
    end

    assign aux_pin_free         = ~xtal_sel & ~drive_clk;
    assign clock_input_pin_free = (ctrl_q.src == SRC_INT);
    assign crystal_amp_enable   = xtal_sel & osc_allow;
    assign crystal_range_select = ctrl_q.range;
    assign rc_osc_enable        = (ctrl_q.src == SRC_RC) & osc_allow;
    // no interrupt or break-sensitive flag exists here

    // -----------------------------
    // checks
    // -----------------------------
    two_edges_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_GAP_IN |-> $past(edge_q) == 2'h1)
        else $error("switch before two edges");

    eng_before_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(eng_q) |-> $past(int_run) == 1'b1 || !$past(osc_allow))
        else $error("internal stopped before engaged");

    int_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
        eng_q |-> !int_run)
        else $error("internal running while engaged");

    return_int_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_EXT && back_req |=> ##1 !eng_q)
        else $error("external not released");

    ext_outen_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q.src == SRC_EXT |=> !ctrl_q.out_en || ctrl_q.src != SRC_EXT)
        else $error("out enable kept in ext mode");

    xtal_pin_a: assert property (@(posedge pclk) disable iff (!presetn)
        xtal_sel |=> aux_pin_oe)
        else $error("aux pin not driven by amplifier");

    dbl_half_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(quad_q) |-> dbl_q != $past(dbl_q))
        else $error("double rate did not toggle");

    stop_halt_a: assert property (@(posedge pclk) disable iff (!presetn)
        stop_mode && !oscillator_run_enable && !ctrl_q.keep_stop
        |-> !int_run && !crystal_amp_enable)
        else $error("oscillator ran in stop");

    engaged_rd_a: assert property (@(posedge pclk) disable iff (!presetn)
        rd_en && paddr == CTRL_OFS |=> prdata[ENG_POS] == $past(eng_q))
        else $error("engaged bit misread");

    quad_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == S_INT |=> quad_q == $past(int_clk_q))
        else $error("quad clock not following source");

endmodule // clock_source_select_switch

/* File: verification/clock_consumer_model.sv */
// consumer side of the bus clocks: counts their rising edges
// assumes both bus clocks are registered on pclk
`timescale 1ns/1ps
module clock_consumer_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        quad_rate_bus_clock,
    input  wire logic        double_rate_bus_clock,
    output logic [15:0]      quad_rises_q,
    output logic [15:0]      double_rises_q
);
    logic quad_q;
    logic dbl_q;

    // edge counters, read by the bench as activity probes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            quad_q         <= 1'b0;
            dbl_q          <= 1'b0;
            quad_rises_q   <= 16'h0000;
            double_rises_q <= 16'h0000;
        end else begin
            quad_q <= quad_rate_bus_clock;
            dbl_q  <= double_rate_bus_clock;
            if (quad_rate_bus_clock && !quad_q) quad_rises_q <= quad_rises_q + 16'h0001;
            if (double_rate_bus_clock && !dbl_q) double_rises_q <= double_rises_q + 16'h0001;
        end
    end
endmodule // clock_consumer_model

/* File: verification/tb.sv */
// self-checking bench for the clock source switch
// assumes zero-wait apb slave and a scaled internal oscillator
`timescale 1ns/1ps
module tb;
    import osc_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        stop_mode, run_en, ext_clk, ext_run, er;
    logic        aux_pin_o, aux_pin_oe, aux_pin_free, clock_input_pin_free;
    logic        crystal_amp_enable, rc_osc_enable, internal_osc_clock;
    logic        quad_rate_bus_clock, double_rate_bus_clock, external_clock_engaged;
    logic [1:0]  crystal_range_select;
    logic [15:0] qr, dr, q0;
    int          mismatches, checked, p, n, t;
    logic [11:0] half_tab [3] = '{HALF_4M0, HALF_8M0, HALF_12M8};
    logic [15:0] pin_ctrl [5] = '{16'h0100, 16'h0000, 16'h0102, 16'h0002, 16'h0101};
    logic [4:0]  pin_exp  [5] = '{5'h14, 5'h0c, 5'h11, 5'h09, 5'h08};

    clock_source_select_switch clock_source_select_switch_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
        .oscillator_run_enable(run_en), .clock_input_pin(ext_clk), .crystal_clock(ext_clk),
        .resistor_cap_clock(ext_clk), .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe),
        .aux_pin_free(aux_pin_free), .clock_input_pin_free(clock_input_pin_free),
        .crystal_amp_enable(crystal_amp_enable), .crystal_range_select(crystal_range_select),
        .rc_osc_enable(rc_osc_enable), .internal_osc_clock(internal_osc_clock),
        .quad_rate_bus_clock(quad_rate_bus_clock), .double_rate_bus_clock(double_rate_bus_clock),
        .external_clock_engaged(external_clock_engaged));
    clock_consumer_model clock_consumer_model_inst (.pclk(pclk), .presetn(presetn),
        .quad_rate_bus_clock(quad_rate_bus_clock), .double_rate_bus_clock(double_rate_bus_clock),
        .quad_rises_q(qr), .double_rises_q(dr));

    // ----------------------------------------
    // clocks and helpers
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // external source, stands still while not running
    always #100 if (ext_run) ext_clk = ~ext_clk;

    task automatic report_and_stop();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(1'b0, a, 16'h0000);
        chk(nm, e, rd);
    endtask

    // pclk cycles between two rising edges of a bus clock
    task automatic period(input logic dbl, output int cyc);
        int hits;
        logic prev, cur;
        hits = 0;
        prev = 1'b1;
        cyc = 0;
        for (int k = 0; k < 12000 && hits < 2; k++) begin
            @(posedge pclk);
            cur = dbl ? double_rate_bus_clock : quad_rate_bus_clock;
            if (cur === 1'b1 && prev === 1'b0) begin
                hits++;
                if (hits == 1) cyc = 0;
            end
            if (hits < 2) cyc++;
            prev = cur;
        end
        if (hits < 2) cyc = -1;
    endtask

    task automatic toggles(input int cnt, output int tg);
        logic prev;
        tg = 0;
        prev = internal_osc_clock;
        repeat (cnt) begin
            @(posedge pclk);
            if (internal_osc_clock !== prev) tg++;
            prev = internal_osc_clock;
        end
    endtask

    task automatic quad_delta(output int d);
        repeat (20) @(posedge pclk);
        q0 = qr;
        repeat (1700) @(posedge pclk);
        d = int'(qr - q0);
    endtask

    initial begin
        repeat (60000) @(posedge pclk);
        mismatches++;
        report_and_stop();
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {stop_mode, ext_clk, ext_run, mismatches, checked} = '0;
        run_en = 1'b1;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("cin_free_rst", 1, clock_input_pin_free);
        rd_chk(CTRL_OFS, 0, "ctrl_rst");
        rd_chk(TRIM_OFS, {24'h0000_00, TRIM_RST}, "trim_rst");
        apb(1'b0, 8'h0c, 16'h0000);
        chk("unmapped_err", 32'h0000_0001, {31'h0, er});
        chk("unmapped_rd", 32'h0000_0000, rd);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, CTRL_OFS, 16'(i << FRQ_POS));
            period(1'b0, p);
            chk("quad_period", half_tab[i] * 2, p);
        end
        period(1'b1, p);
        chk("double_period", HALF_12M8 * 4, p);
        apb(1'b1, TRIM_OFS, 16'h00ff);
        rd_chk(TRIM_OFS, 32'h0000_00ff, "trim_rw");
        period(1'b0, p);
        chk("trim_slow", 1, p > HALF_12M8 * 2);
        apb(1'b1, TRIM_OFS, 16'h0000);
        period(1'b0, p);
        chk("trim_fast", 1, p < HALF_12M8 * 2);
        apb(1'b1, TRIM_OFS, {8'h00, TRIM_RST});
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, CTRL_OFS, pin_ctrl[i]);
            repeat (3) @(posedge pclk);
            chk("pin_use", pin_exp[i], {aux_pin_oe, aux_pin_free, clock_input_pin_free,
                crystal_amp_enable, rc_osc_enable});
        end
        // clock out on the aux pin in internal mode
        apb(1'b1, CTRL_OFS, 16'h0100);
        n = 0;
        repeat (1200) begin
            @(posedge pclk);
            if (aux_pin_o !== quad_rate_bus_clock) n++;
        end
        chk("aux_clk_out", 0, n);
        for (int r = 0; r < 3; r++) begin
            apb(1'b1, CTRL_OFS, 16'h0103 | 16'(r << RNG_POS));
            repeat (3) @(posedge pclk);
            chk("xtal_pins", 1, {aux_pin_free, clock_input_pin_free, crystal_amp_enable});
            chk("xtal_range", r, crystal_range_select);
        end
        // request before the source runs, then start it
        apb(1'b1, CTRL_OFS, 16'h0111);
        rd_chk(CTRL_OFS, 32'h0000_0011, "ext_out_en");
        apb(1'b1, CTRL_OFS, 16'h0151);
        repeat (40) @(posedge pclk);
        chk("engaged_early", 0, external_clock_engaged);
        ext_run = 1'b1;
        for (n = 0; n < 200 && external_clock_engaged !== 1'b1; n++) @(posedge pclk);
        chk("engaged_after_edges", 32'h0000_0003, {external_clock_engaged, n > 10});
        toggles(1500, t);
        chk("int_stopped", 0, t);
        period(1'b0, p);
        chk("ext_quad", 10, p);
        period(1'b1, p);
        chk("ext_double", 20, p);
        rd_chk(CTRL_OFS, 32'h0000_00d1, "ctrl_engaged");
        apb(1'b1, CTRL_OFS, 16'h0010);
        for (n = 0; n < 50 && external_clock_engaged !== 1'b0; n++) @(posedge pclk);
        chk("disengaged", 0, external_clock_engaged);
        period(1'b0, p);
        chk("int_back", HALF_8M0 * 2, p);
        ext_run = 1'b0;
        // stop mode with and without the keep bit
        apb(1'b1, CTRL_OFS, 16'h0020);
        stop_mode <= 1'b1;
        run_en    <= 1'b0;
        quad_delta(t);
        chk("stop_halt", 0, t);
        apb(1'b1, CTRL_OFS, 16'h0220);
        quad_delta(t);
        chk("keep_in_stop", 1, t > 0);
        apb(1'b1, CTRL_OFS, 16'h0020);
        run_en <= 1'b1;
        quad_delta(t);
        chk("run_enabled", 1, t > 0);
        stop_mode <= 1'b0;
        chk("double_rises", 1, dr > 0);
        report_and_stop();
    end
endmodule // tb
